//--- inc/can_mode_pkg.sv
// Package: constants and types for the CAN mode and transmit control block
package can_mode_pkg;

  // Register indices on the plain register port
  localparam logic [5:0] ADDR_MODE_CTRL = 6'h00;
  localparam logic [5:0] ADDR_MODE_STAT = 6'h01;
  localparam logic [5:0] ADDR_CONFIG = 6'h02;
  localparam logic [5:0] ADDR_BIT_TIMING = 6'h03;
  localparam logic [5:0] ADDR_FILTER = 6'h04;
  localparam logic [5:0] ADDR_MASK = 6'h05;
  localparam logic [5:0] ADDR_RX_CTRL = 6'h06;
  localparam logic [5:0] ADDR_ERR_CAPTURE = 6'h07;
  localparam logic [5:0] ADDR_ERR_COUNT = 6'h08;
  localparam logic [5:0] ADDR_WAKE = 6'h09;
  localparam logic [5:0] ADDR_TX_FLAGS = 6'h0A;
  localparam logic [5:0] ADDR_TXB_BASE = 6'h10;
  localparam logic [5:0] ADDR_TXB_STRIDE = 6'h10;

  // Buffer geometry
  localparam int TXB_COUNT = 3;
  localparam int TXB_BYTES = 14;
  localparam logic [3:0] TXB_CTRL_IDX = 4'h0;

  // Transmit buffer control byte fields
  localparam int TXC_PRIO_LO = 0;
  localparam int TXC_IE = 2;
  localparam int TXC_REQ = 3;
  localparam int TXC_ERR = 4;
  localparam int TXC_ARB = 5;
  localparam int TXC_ABT = 6;

  // Module control and receive mode byte fields
  localparam int MC_ABORT_ALL = 4;
  localparam int MC_RXM_LO = 0;

  // Recessive bits taken as an idle bus before disable
  localparam logic [3:0] IDLE_BITS = 4'hB;
  localparam logic [1:0] RXM_ERROR_RECOG = 2'h3;

  // Operating modes, written out in binary
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_DISABLE = 3'b001,
    MODE_LOOPBACK = 3'b010,
    MODE_LISTEN = 3'b011,
    MODE_CONFIG = 3'b100
  } op_mode_t;

  // Reset values
  localparam logic [7:0] MODE_CTRL_RST = 8'h80;

  // Bus request group carried as one struct
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Events from the protocol engine
  typedef struct packed {
    logic done;
    logic error;
    logic arb_lost;
  } tx_result_t;

  // Error capture snapshot
  typedef struct packed {
    logic sample;
    logic [6:0] state_vec;
    logic [7:0] bit_count;
  } err_capture_t;

endpackage

//--- hdl/can_mode_ctrl.sv
// Module: CAN operating mode controller and transmit buffer scheduler
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module can_mode_ctrl #(
  parameter int NUM_TXB = can_mode_pkg::TXB_COUNT,
  parameter int TXB_LEN = can_mode_pkg::TXB_BYTES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire can_mode_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic bus_rx,
  input wire logic bit_tick,
  input wire logic frame_active,
  input wire can_mode_pkg::tx_result_t tx_result,
  input wire logic proto_error,
  input wire can_mode_pkg::err_capture_t err_snapshot,
  input wire logic [7:0] tx_err_count_in,
  input wire logic [7:0] rx_err_count_in,
  output logic tx_start,
  output logic [1:0] tx_sel,
  output logic tx_enable,
  output logic ack_enable,
  output logic loopback,
  output logic rx_enable,
  output logic err_count_clear,
  output logic err_count_hold,
  output logic module_clk_en,
  output logic tx_pin_release,
  output logic rx_pin_release,
  output logic err_dump,
  output logic tx_done_irq,
  output logic tx_err_irq,
  output logic wake_irq,
  output logic [7:0] config_q,
  output logic [7:0] bit_timing_q,
  output logic [7:0] filter_q,
  output logic [7:0] mask_q
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  can_mode_pkg::op_mode_t mode_q;
  logic [7:0] mode_ctrl_q;
  logic [2:0] mode_request;
  logic [7:0] rx_ctrl_q;
  logic [3:0] idle_cnt_q;
  logic bus_idle;
  logic tx_busy_q;
  logic [1:0] cur_q;
  logic [NUM_TXB-1:0] transmit_request_q;
  logic [NUM_TXB-1:0] tx_aborted_flag_q;
  logic [NUM_TXB-1:0] tx_arbitration_lost_q;
  logic [NUM_TXB-1:0] tx_error_flag_q;
  logic [NUM_TXB-1:0] tx_done_flag_q;
  logic [NUM_TXB-1:0] abort_pend_q;
  logic [1:0] tx_priority_q [NUM_TXB];
  logic [NUM_TXB-1:0] tx_done_interrupt_enable_q;
  logic [7:0] txb_mem [NUM_TXB][TXB_LEN];
  logic invalid_message_flag_q;
  logic wake_flag_q;
  logic wake_interrupt_enable_q;
  can_mode_pkg::err_capture_t capture_q;
  logic in_config;
  logic pending_any;
  logic [1:0] best;
  logic best_valid;
  logic abort_all;
  logic [7:0] rdata_d;
  logic [1:0] buf_idx;
  logic [3:0] buf_off;
  logic buf_hit;
  logic [NUM_TXB-1:0] req_set;
  logic [NUM_TXB-1:0] req_clr_sw;

  assign mode_request = mode_ctrl_q[7:5];
  assign in_config = (mode_q == can_mode_pkg::MODE_CONFIG);
  assign pending_any = |transmit_request_q;
  assign bus_idle = (idle_cnt_q >= can_mode_pkg::IDLE_BITS);
  assign abort_all = mode_ctrl_q[can_mode_pkg::MC_ABORT_ALL];

  // Decode of transmit buffer window
  assign buf_hit = (req.addr >= can_mode_pkg::ADDR_TXB_BASE)
                 && ({1'b0, req.addr} < 7'(can_mode_pkg::ADDR_TXB_BASE) + 7'(NUM_TXB) * 7'(can_mode_pkg::ADDR_TXB_STRIDE));
  assign buf_idx = 2'((req.addr - can_mode_pkg::ADDR_TXB_BASE) >> 4);
  assign buf_off = req.addr[3:0];

  // ---------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------
  // Module control register and receive mode register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ctrl_q <= can_mode_pkg::MODE_CTRL_RST;
      rx_ctrl_q <= 8'h00;
      wake_interrupt_enable_q <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == can_mode_pkg::ADDR_MODE_CTRL) begin
        mode_ctrl_q <= req.wdata;
      end
      if (req.addr == can_mode_pkg::ADDR_RX_CTRL) begin
        rx_ctrl_q <= req.wdata;
      end
      if (req.addr == can_mode_pkg::ADDR_WAKE) begin
        wake_interrupt_enable_q <= req.wdata[1];
      end
    end
  end

  // Count recessive bits to detect an idle bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt_q <= 4'h0;
    end else if (bit_tick) begin
      if (!bus_rx) begin
        idle_cnt_q <= 4'h0;
      end else if (!bus_idle) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  // Mode status follows the request once it is safe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= can_mode_pkg::MODE_CONFIG;
    end else if (mode_request != mode_q) begin
      case (mode_request)
        can_mode_pkg::MODE_CONFIG: begin
          if (!pending_any && !tx_busy_q && !frame_active) begin
            mode_q <= can_mode_pkg::MODE_CONFIG;
          end
        end
        can_mode_pkg::MODE_DISABLE: begin
          if (!pending_any && !tx_busy_q && (!frame_active || bus_idle)) begin
            mode_q <= can_mode_pkg::MODE_DISABLE;
          end
        end
        can_mode_pkg::MODE_NORMAL, can_mode_pkg::MODE_LISTEN, can_mode_pkg::MODE_LOOPBACK: begin
          if (!pending_any && !tx_busy_q) begin
            mode_q <= can_mode_pkg::op_mode_t'(mode_request);
          end
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // Per-mode controls toward protocol engine and pins
  always_comb begin
    tx_enable = (mode_q == can_mode_pkg::MODE_NORMAL) || (mode_q == can_mode_pkg::MODE_LOOPBACK);
    ack_enable = (mode_q == can_mode_pkg::MODE_NORMAL);
    loopback = (mode_q == can_mode_pkg::MODE_LOOPBACK);
    rx_enable = !in_config && (mode_q != can_mode_pkg::MODE_DISABLE);
    err_count_clear = in_config || (mode_q == can_mode_pkg::MODE_LISTEN);
    err_count_hold = (mode_q == can_mode_pkg::MODE_DISABLE);
    module_clk_en = (mode_q != can_mode_pkg::MODE_DISABLE) || frame_active;
    tx_pin_release = (mode_q == can_mode_pkg::MODE_DISABLE) || loopback;
    rx_pin_release = (mode_q == can_mode_pkg::MODE_DISABLE);
  end

  // ---------------------------------------------------------------
  // Protected registers
  // ---------------------------------------------------------------
  // Writes land only while in configuration mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_q <= 8'h00;
      bit_timing_q <= 8'h00;
      filter_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (req.wr && in_config) begin
      if (req.addr == can_mode_pkg::ADDR_CONFIG) begin
        config_q <= req.wdata;
      end
      if (req.addr == can_mode_pkg::ADDR_BIT_TIMING) begin
        bit_timing_q <= req.wdata;
      end
      if (req.addr == can_mode_pkg::ADDR_FILTER) begin
        filter_q <= req.wdata;
      end
      if (req.addr == can_mode_pkg::ADDR_MASK) begin
        mask_q <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wake and error capture
  // ---------------------------------------------------------------
  // Wake flag set by dominant bus while disabled; set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_flag_q <= 1'b0;
    end else if ((mode_q == can_mode_pkg::MODE_DISABLE) && !bus_rx) begin
      wake_flag_q <= 1'b1;
    end else if (req.wr && (req.addr == can_mode_pkg::ADDR_WAKE) && req.wdata[0]) begin
      wake_flag_q <= 1'b0;
    end
  end
  assign wake_irq = wake_flag_q && wake_interrupt_enable_q;

  // Snapshot on protocol error in error recognition
  assign err_dump = proto_error && rx_enable
                  && (rx_ctrl_q[can_mode_pkg::MC_RXM_LO +: 2] == can_mode_pkg::RXM_ERROR_RECOG);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_q <= '0;
    end else if (err_dump) begin
      capture_q <= err_snapshot;
    end
  end

  // ---------------------------------------------------------------
  // Transmit buffers
  // ---------------------------------------------------------------
  // Buffer storage; refused while its request is set
  always_ff @(posedge clk) begin
    if (req.wr && buf_hit && (buf_off != can_mode_pkg::TXB_CTRL_IDX)
        && (32'(buf_off) < TXB_LEN) && !transmit_request_q[buf_idx]) begin
      txb_mem[buf_idx][buf_off] <= req.wdata;
    end
  end

  // Highest priority ready buffer, ties to higher number
  always_comb begin
    best = 2'h0;
    best_valid = 1'b0;
    for (int i = 0; i < NUM_TXB; i++) begin
      if (transmit_request_q[i] && !abort_pend_q[i]
          && (!best_valid || tx_priority_q[i] >= tx_priority_q[best])) begin
        best = 2'(i);
        best_valid = 1'b1;
      end
    end
  end

  // Start a frame when the bus is idle and transmit allowed
  assign tx_start = best_valid && !tx_busy_q && tx_enable && bus_idle && !frame_active
                  && (mode_request == mode_q);
  assign tx_sel = cur_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_busy_q <= 1'b0;
      cur_q <= 2'h0;
      invalid_message_flag_q <= 1'b0;
    end else begin
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        cur_q <= best;
      end else if (tx_busy_q && (tx_result.done || tx_result.error || tx_result.arb_lost)) begin
        tx_busy_q <= 1'b0;
      end
      if (tx_busy_q && tx_result.error) begin
        invalid_message_flag_q <= 1'b1;
      end else if (req.wr && (req.addr == can_mode_pkg::ADDR_TX_FLAGS) && req.wdata[7]) begin
        invalid_message_flag_q <= 1'b0;
      end
    end
  end

  // Per-buffer control and flags
  genvar g;
  generate
    for (g = 0; g < NUM_TXB; g++) begin : g_txb
      logic ctrl_wr;
      logic mine;
      assign ctrl_wr = req.wr && buf_hit && (buf_idx == 2'(g)) && (buf_off == can_mode_pkg::TXB_CTRL_IDX);
      assign mine = tx_busy_q && (cur_q == 2'(g));
      assign req_set[g] = ctrl_wr && req.wdata[can_mode_pkg::TXC_REQ] && !transmit_request_q[g];
      assign req_clr_sw[g] = (ctrl_wr && !req.wdata[can_mode_pkg::TXC_REQ]) || abort_all;

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          transmit_request_q[g] <= 1'b0;
          tx_aborted_flag_q[g] <= 1'b0;
          tx_arbitration_lost_q[g] <= 1'b0;
          tx_error_flag_q[g] <= 1'b0;
          tx_done_flag_q[g] <= 1'b0;
          abort_pend_q[g] <= 1'b0;
          tx_priority_q[g] <= 2'h0;
          tx_done_interrupt_enable_q[g] <= 1'b0;
        end else begin
          if (ctrl_wr && !transmit_request_q[g]) begin
            tx_priority_q[g] <= req.wdata[can_mode_pkg::TXC_PRIO_LO +: 2];
            tx_done_interrupt_enable_q[g] <= req.wdata[can_mode_pkg::TXC_IE];
          end
          if (req_set[g]) begin
            transmit_request_q[g] <= 1'b1;
            tx_aborted_flag_q[g] <= 1'b0;
            tx_arbitration_lost_q[g] <= 1'b0;
            tx_error_flag_q[g] <= 1'b0;
          end else if (mine && tx_result.done) begin
            transmit_request_q[g] <= 1'b0;
            abort_pend_q[g] <= 1'b0;
          end else if (mine && (tx_result.error || tx_result.arb_lost)) begin
            tx_error_flag_q[g] <= tx_result.error;
            tx_arbitration_lost_q[g] <= tx_result.arb_lost;
            if (abort_pend_q[g] || req_clr_sw[g]) begin
              transmit_request_q[g] <= 1'b0;
              tx_aborted_flag_q[g] <= 1'b1;
              abort_pend_q[g] <= 1'b0;
            end
          end else if (transmit_request_q[g] && req_clr_sw[g]) begin
            if (mine || (tx_start && best == 2'(g))) begin
              abort_pend_q[g] <= 1'b1;
            end else begin
              transmit_request_q[g] <= 1'b0;
              tx_aborted_flag_q[g] <= 1'b1;
            end
          end
          if (mine && tx_result.done) begin
            tx_done_flag_q[g] <= 1'b1;
          end else if (req.wr && (req.addr == can_mode_pkg::ADDR_TX_FLAGS) && req.wdata[g]) begin
            tx_done_flag_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign tx_done_irq = |(tx_done_flag_q & tx_done_interrupt_enable_q);
  assign tx_err_irq = invalid_message_flag_q;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read mux, data returned the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      can_mode_pkg::ADDR_MODE_CTRL: rdata_d = mode_ctrl_q;
      can_mode_pkg::ADDR_MODE_STAT: rdata_d = {mode_q, 4'h0, in_config};
      can_mode_pkg::ADDR_CONFIG: rdata_d = config_q;
      can_mode_pkg::ADDR_BIT_TIMING: rdata_d = bit_timing_q;
      can_mode_pkg::ADDR_FILTER: rdata_d = filter_q;
      can_mode_pkg::ADDR_MASK: rdata_d = mask_q;
      can_mode_pkg::ADDR_RX_CTRL: rdata_d = rx_ctrl_q;
      can_mode_pkg::ADDR_ERR_CAPTURE: rdata_d = capture_q[7:0];
      can_mode_pkg::ADDR_ERR_COUNT: rdata_d = capture_q[15:8];
      can_mode_pkg::ADDR_WAKE: rdata_d = {6'h00, wake_interrupt_enable_q, wake_flag_q};
      can_mode_pkg::ADDR_TX_FLAGS: rdata_d = {invalid_message_flag_q, 4'h0, tx_done_flag_q[2:0]};
      default: begin
        if (buf_hit && buf_off == can_mode_pkg::TXB_CTRL_IDX) begin
          rdata_d = {1'b0, tx_aborted_flag_q[buf_idx], tx_arbitration_lost_q[buf_idx],
                     tx_error_flag_q[buf_idx], transmit_request_q[buf_idx],
                     tx_done_interrupt_enable_q[buf_idx], tx_priority_q[buf_idx]};
        end else if (buf_hit && 32'(buf_off) < TXB_LEN) begin
          rdata_d = txb_mem[buf_idx][buf_off];
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // can_mode_ctrl

//--- tb/can_mode_ctrl_chk.sv
// Checker: port assertions for the mode and transmit controller
`timescale 1ns/1ns
module can_mode_ctrl_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic frame_active,
  input wire can_mode_pkg::tx_result_t tx_result,
  input wire logic proto_error,
  input wire logic tx_start,
  input wire logic tx_enable,
  input wire logic ack_enable,
  input wire logic loopback,
  input wire logic rx_enable,
  input wire logic err_count_clear,
  input wire logic err_count_hold,
  input wire logic wake_irq,
  input wire logic module_clk_en,
  input wire logic tx_pin_release,
  input wire logic rx_pin_release,
  input wire logic err_dump,
  input wire logic tx_done_irq,
  input wire logic tx_err_irq,
  input wire logic [7:0] config_q,
  input wire logic [7:0] bit_timing_q,
  input wire logic [7:0] filter_q,
  input wire logic [7:0] mask_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Configuration seen at the pins: counters cleared and no reception
  wire logic cfg_mode = err_count_clear && !rx_enable;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  mode_gate_a: assert property (!tx_enable |-> !tx_start)
    else $error("frame started while sending is off");
  start_idle_a: assert property (tx_start |-> !frame_active)
    else $error("frame started on a busy bus");
  cfg_silent_a: assert property (cfg_mode |-> !tx_enable && !tx_start)
    else $error("configuration mode not silent");
  loop_quiet_a: assert property (loopback |-> tx_pin_release && !ack_enable)
    else $error("loopback drives the bus");
  disable_pins_a: assert property (!module_clk_en |-> tx_pin_release && rx_pin_release && !tx_enable)
    else $error("disable mode keeps the pins");
  prot_lock_a: assert property (!cfg_mode |=> $stable({config_q, bit_timing_q, filter_q, mask_q}))
    else $error("protected register changed outside configuration");
  one_start_a: assert property (tx_start |=> !tx_start [*4])
    else $error("second start during a frame");
  done_irq_a: assert property ($rose(tx_done_irq) |-> $past(tx_result.done))
    else $error("done interrupt without success");
  err_irq_a: assert property ($rose(tx_err_irq) |-> $past(tx_result.error))
    else $error("error interrupt without error");
  dump_a: assert property (err_dump |-> proto_error)
    else $error("dump without protocol error");
  hold_cnt_a: assert property (err_count_hold |-> !rx_enable && !tx_enable && !err_count_clear)
    else $error("disable mode not silent or counters not kept");
  wake_only_a: assert property ($rose(wake_irq) |-> rx_pin_release)
    else $error("wake interrupt outside disable mode");
  start_c: cover property (tx_start);
  done_c: cover property ($rose(tx_done_irq));
  dump_c: cover property (err_dump);
endmodule // can_mode_ctrl_chk

bind can_mode_ctrl can_mode_ctrl_chk chk (
  .clk(clk), .sys_rst(sys_rst), .frame_active(frame_active), .tx_result(tx_result),
  .proto_error(proto_error), .tx_start(tx_start), .tx_enable(tx_enable), .ack_enable(ack_enable),
  .loopback(loopback), .rx_enable(rx_enable), .err_count_clear(err_count_clear),
  .err_count_hold(err_count_hold), .wake_irq(wake_irq),
  .module_clk_en(module_clk_en), .tx_pin_release(tx_pin_release), .rx_pin_release(rx_pin_release),
  .err_dump(err_dump), .tx_done_irq(tx_done_irq), .tx_err_irq(tx_err_irq), .config_q(config_q),
  .bit_timing_q(bit_timing_q), .filter_q(filter_q), .mask_q(mask_q)
);

//--- tb/can_bus_node.sv
// Partner: protocol engine and bus as seen by the controller
`timescale 1ns/1ns
module can_bus_node (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tx_start,
  input wire logic hold,
  input wire logic [1:0] kind,
  output logic bus_rx,
  output logic bit_tick,
  output logic frame_active,
  output can_mode_pkg::tx_result_t tx_result
);
  logic [4:0] cnt_q;
  logic flip_q;
  // Bit clock: one tick every second cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= !bit_tick;
    end
  end
  // Frame timer: each start gets one result pulse of the commanded kind
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
      flip_q <= 1'b1; // Out of phase with the tick so frames read dominant
      tx_result <= '0;
    end else begin
      flip_q <= !flip_q;
      tx_result <= '0;
      if (tx_start) begin
        cnt_q <= 5'h10;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          tx_result <= {kind == 2'h0, kind == 2'h1, kind == 2'h2};
        end
      end
    end
  end
  // Bus level: recessive idle, toggling in a frame, dominant while held
  assign frame_active = hold || (cnt_q != 5'h00);
  assign bus_rx = hold ? 1'b0 : (cnt_q == 5'h00) || flip_q;
endmodule // can_bus_node

//--- tb/tb_can_mode_ctrl.sv
// Testbench: self-checking bench for the mode and transmit controller
`timescale 1ns/1ns
module tb_can_mode_ctrl;
  logic clk, sys_rst, hold, proto_error, rd_d, start_d, bus_rx, bit_tick, frame_active, tx_start;
  logic [1:0] kind, tx_sel;
  logic [7:0] rdata;
  logic [1:0] p [3];
  logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
  can_mode_pkg::reg_req_t req;
  can_mode_pkg::tx_result_t tx_result;
  can_mode_pkg::err_capture_t snap;
  logic [7:0] exp_q [$];
  logic [1:0] sel_q [$];
  int bad_count, num_checks, r, i, j, n;

  can_mode_ctrl uut (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .bus_rx(bus_rx), .bit_tick(bit_tick),
    .frame_active(frame_active), .tx_result(tx_result), .proto_error(proto_error), .err_snapshot(snap),
    .tx_err_count_in(8'h00), .rx_err_count_in(8'h00), .tx_start(tx_start), .tx_sel(tx_sel),
    .tx_enable(), .ack_enable(), .loopback(), .rx_enable(), .err_count_clear(), .err_count_hold(),
    .module_clk_en(), .tx_pin_release(), .rx_pin_release(), .err_dump(), .tx_done_irq(), .tx_err_irq(),
    .wake_irq(), .config_q(), .bit_timing_q(), .filter_q(), .mask_q()
  );
  can_bus_node node (
    .clk(clk), .sys_rst(sys_rst), .tx_start(tx_start), .hold(hold), .kind(kind), .bus_rx(bus_rx),
    .bit_tick(bit_tick), .frame_active(frame_active), .tx_result(tx_result)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] ba(input int b);
    return 6'(can_mode_pkg::ADDR_TXB_BASE + can_mode_pkg::ADDR_TXB_STRIDE * b);
  endfunction
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One register cycle, then one idle cycle; a read notes its expectation
  task automatic bus(input logic [5:0] a, input logic [7:0] d, input logic w, input logic [7:0] e);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  // Failed frame with an abort landing while it is on the bus
  task automatic fail_abort(input int b, input logic [1:0] k, input logic [7:0] c, input logic [7:0] e);
    kind <= k;
    sel_q.push_back(2'(b));
    bus(ba(b), c, 1'b1, 8'h00);
    for (n = 0; n < 200 && frame_active !== 1'b1; n++) @(negedge clk);
    if (n == 200) bad_count++;
    @(posedge clk);
    bus(ba(b), c & 8'hF7, 1'b1, 8'h00);
    idle(40);
    bus(ba(b), 8'h00, 1'b0, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Clock and watchdog, the run needs about 530 cycles
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end
  // Monitor: read data and frame index against the oldest note
  always @(posedge clk) begin
    rd_d <= req.rd;
    start_d <= tx_start;
  end
  always @(negedge clk) begin
    if (rd_d) check("rdata", exp_q.pop_front(), rdata);
    if (start_d) check("tx_sel", {6'h00, sel_q.pop_front()}, {6'h00, tx_sel});
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    req = '0;
    hold = 1'b0;
    kind = 2'h0;
    proto_error = 1'b0;
    snap = '0;
    r = $urandom(70353);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(can_mode_pkg::ADDR_MODE_CTRL, 8'h00, 1'b0, 8'h80);
    bus(can_mode_pkg::ADDR_MODE_STAT, 8'h00, 1'b0, 8'h81);
    bus(6'h0B, 8'h00, 1'b0, 8'h00);
    r = $urandom;
    bus(can_mode_pkg::ADDR_CONFIG, r[7:0], 1'b1, 8'h00);
    bus(can_mode_pkg::ADDR_CONFIG, 8'h00, 1'b0, r[7:0]);
    bus(can_mode_pkg::ADDR_WAKE, 8'h02, 1'b1, 8'h00);
    $display("test reset done");
    foreach (codes[k]) begin
      bus(can_mode_pkg::ADDR_MODE_CTRL, {codes[k], 5'h00}, 1'b1, 8'h00);
      idle(30);
      bus(can_mode_pkg::ADDR_MODE_STAT, 8'h00, 1'b0, {codes[k], 5'h00});
      if (codes[k] == 3'h1) begin
        hold <= 1'b1;
        idle(3);
        hold <= 1'b0;
        bus(can_mode_pkg::ADDR_WAKE, 8'h00, 1'b0, 8'h03);
      end
    end
    bus(can_mode_pkg::ADDR_CONFIG, ~r[7:0], 1'b1, 8'h00);
    bus(can_mode_pkg::ADDR_CONFIG, 8'h00, 1'b0, r[7:0]);
    $display("test modes done");
    hold <= 1'b1;
    for (i = 0; i < 3; i++) begin
      p[i] = 2'($urandom);
      bus(ba(i) + 6'h0D, 8'hA0 + 8'(i), 1'b1, 8'h00);
      bus(ba(i), {6'h03, p[i]}, 1'b1, 8'h00);
    end
    bus(ba(0) + 6'h0D, 8'h55, 1'b1, 8'h00);
    bus(ba(0) + 6'h0D, 8'h00, 1'b0, 8'hA0);
    for (j = 3; j >= 0; j--)
      for (i = 2; i >= 0; i--)
        if (p[i] == 2'(j)) sel_q.push_back(2'(i));
    hold <= 1'b0;
    idle(200);
    for (i = 0; i < 3; i++) bus(ba(i), 8'h00, 1'b0, {6'h01, p[i]});
    bus(can_mode_pkg::ADDR_TX_FLAGS, 8'h00, 1'b0, 8'h07);
    $display("test priority done");
    bus(can_mode_pkg::ADDR_RX_CTRL, 8'h03, 1'b1, 8'h00);
    snap <= 16'($urandom);
    proto_error <= 1'b1;
    @(posedge clk);
    proto_error <= 1'b0;
    bus(can_mode_pkg::ADDR_ERR_CAPTURE, 8'h00, 1'b0, snap.bit_count);
    bus(can_mode_pkg::ADDR_ERR_COUNT, 8'h00, 1'b0, {snap.sample, snap.state_vec});
    fail_abort(0, 2'h1, 8'h0F, 8'h57);
    bus(can_mode_pkg::ADDR_TX_FLAGS, 8'h00, 1'b0, 8'h87);
    fail_abort(1, 2'h2, 8'h0E, 8'h66);
    $display("test failures done");
    hold <= 1'b1;
    bus(ba(0), 8'h0F, 1'b1, 8'h00);
    bus(ba(0), 8'h00, 1'b0, 8'h0F);
    bus(can_mode_pkg::ADDR_MODE_CTRL, 8'h60, 1'b1, 8'h00);
    bus(can_mode_pkg::ADDR_MODE_STAT, 8'h00, 1'b0, 8'h00);
    bus(can_mode_pkg::ADDR_MODE_CTRL, 8'h80, 1'b1, 8'h00);
    bus(ba(0), 8'h07, 1'b1, 8'h00);
    bus(ba(0), 8'h00, 1'b0, 8'h47);
    bus(can_mode_pkg::ADDR_MODE_STAT, 8'h00, 1'b0, 8'h00);
    hold <= 1'b0;
    idle(10);
    bus(can_mode_pkg::ADDR_MODE_STAT, 8'h00, 1'b0, 8'h81);
    idle(3);
    $display("test abort done");
    print_verdict();
  end
endmodule // tb_can_mode_ctrl
